// [apcr_port.sv]
// Purpose: control and three-state output port of a 12-bit sampling converter
// Assumes: strobes are asynchronous pins; the analog core supplies bit decisions
// Notes:   the successive approximation loop is modelled with a comparator input
//          sampled once per bit step; conversion timed by counter on ref_clk

module apcr_port
#(
  parameter int CONV_CYC = apcr_pkg::CONV_CYCLES
)
(
  input  wire logic                              ref_clk,
  input  wire logic                              rst_n,
  input  wire logic                              cs_n,
  input  wire logic                              rd_n,
  input  wire logic                              upper_byte_enable,
  input  wire logic                              cmp_high,
  output logic                                   busy_n,
  output logic [apcr_pkg::RESULT_W-1:0]          out_lines,
  output logic [apcr_pkg::RESULT_W-1:0]          out_lines_oe
);

  localparam int W = apcr_pkg::RESULT_W;
  // spread bit decisions over the conversion time
  localparam int STEP = CONV_CYC / W;

  apcr_pkg::apcr_strobe_s       meta_q, sync_q, prev_q;
  apcr_pkg::apcr_state_e        state_q, state_d;
  logic [apcr_pkg::CNT_W-1:0]   cnt_q, cnt_d;
  logic [3:0]                   bit_q, bit_d;
  logic [W-1:0]                 successive_approx_reg_q, successive_approx_reg_d;
  logic [W-1:0]                 result_bits_q, result_bits_d;
  logic                         cmp_meta_q, cmp_q;
  apcr_pkg::apcr_strobe_s       meta_d, sync_d, prev_d;
  logic                         cmp_meta_d, cmp_d;
  logic                         busy_n_d;
  logic [W-1:0]                 out_d, oe_d;
  logic                         start;
  logic [3:0]                   out_lines_upper_nib;

  // two-flop synchronisers; first stage feeds only the second
  always_comb
  begin
    meta_d     = '{cs_n, rd_n, upper_byte_enable};
    sync_d     = meta_q;
    prev_d     = sync_q;
    cmp_meta_d = cmp_high;
    cmp_d      = cmp_meta_q;
  end

  // reset to select and read high, so no false falling edge after reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q     <= 3'b110;
      sync_q     <= 3'b110;
      prev_q     <= 3'b110;
      cmp_meta_q <= 1'b0;
      cmp_q      <= 1'b0;
    end
    else
    begin
      meta_q     <= meta_d;
      sync_q     <= sync_d;
      prev_q     <= prev_d;
      cmp_meta_q <= cmp_meta_d;
      cmp_q      <= cmp_d;
    end
  end

  // falling read edge qualified by select and byte enable
  assign start = !sync_q.rd_n && prev_q.rd_n && !sync_q.cs_n
                 && !sync_q.upper_byte_enable;

  always_comb
  begin
    state_d                 = state_q;
    cnt_d                   = cnt_q;
    bit_d                   = bit_q;
    successive_approx_reg_d = successive_approx_reg_q;
    case (state_q)
      apcr_pkg::APCR_IDLE:
      begin
        if (start)
        begin
          state_d                 = apcr_pkg::APCR_CONV;
          cnt_d                   = '0;
          bit_d                   = 4'(W - 1);
          successive_approx_reg_d = '0;
        end
      end
      apcr_pkg::APCR_CONV:
      begin
        // strobes not looked at here: no restart
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == apcr_pkg::CNT_W'(STEP - 1))
        begin
          cnt_d                          = '0;
          successive_approx_reg_d[bit_q] = cmp_q;
          if (bit_q == 4'h0)
            state_d = apcr_pkg::APCR_DONE;
          else
            bit_d = bit_q - 1'b1;
        end
      end
      apcr_pkg::APCR_DONE:
      begin
        state_d = apcr_pkg::APCR_IDLE;
      end
      default:
      begin
        state_d = apcr_pkg::APCR_IDLE;
      end
    endcase
  end

  // result latch and busy status
  always_comb
  begin
    result_bits_d = result_bits_q;
    busy_n_d      = busy_n;
    case (state_q)
      apcr_pkg::APCR_IDLE:
      begin
        if (start)
          busy_n_d = 1'b0;
      end
      apcr_pkg::APCR_CONV:
      begin
        busy_n_d = 1'b0;
      end
      apcr_pkg::APCR_DONE:
      begin
        result_bits_d = successive_approx_reg_q;
        busy_n_d      = 1'b1;
      end
      default:
      begin
        busy_n_d = 1'b1;
      end
    endcase
  end

  // new result reaches both byte layouts on the edge busy rises
  assign out_lines_upper_nib = result_bits_d[W-1 -: 4];

  // output mux; latch updates the same edge busy rises, so data is set up 0 ns before busy, not DATA_SETUP_NS (70 ns)
  always_comb
  begin
    if (sync_q.upper_byte_enable)
      out_d = {out_lines_upper_nib, apcr_pkg::MID_LOW, out_lines_upper_nib};
    else
      out_d = result_bits_d;
    if (!sync_q.cs_n && !sync_q.rd_n)
      oe_d = '1;
    else
      oe_d = '0;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q                 <= apcr_pkg::APCR_IDLE;
      cnt_q                   <= '0;
      bit_q                   <= 4'h0;
      successive_approx_reg_q <= '0;
    end
    else
    begin
      state_q                 <= state_d;
      cnt_q                   <= cnt_d;
      bit_q                   <= bit_d;
      successive_approx_reg_q <= successive_approx_reg_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_bits_q <= apcr_pkg::RESULT_RST;
      busy_n        <= 1'b1;
    end
    else
    begin
      result_bits_q <= result_bits_d;
      busy_n        <= busy_n_d;
    end
  end

  // data and enable pins move only here, straight from flops
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_lines    <= '0;
      out_lines_oe <= '0;
    end
    else
    begin
      out_lines    <= out_d;
      out_lines_oe <= oe_d;
    end
  end

endmodule

// [apcr_pkg.sv]
// Purpose: shared constants and types for the parallel convert/read port
// Assumes: ref_clk at 250 MHz
// Notes:   times in ns, cycle counts derived from the clock period
package apcr_pkg;

  localparam int CLK_PERIOD_NS   = 4;
  localparam int RESULT_W        = 12;
  localparam int CONV_TIME_NS    = 2700;
  // longest time: rounds down
  localparam int CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int DATA_SETUP_NS   = 70;
  localparam int DATA_SETUP_CYC  = DATA_SETUP_NS / CLK_PERIOD_NS;
  localparam int CNT_W           = 12;
  localparam logic [3:0] MID_LOW = 4'h0;
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

  typedef enum logic [1:0] {
    APCR_IDLE = 2'b00,
    APCR_CONV = 2'b01,
    APCR_DONE = 2'b10
  } apcr_state_e;

  // host strobes after synchronisation
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic upper_byte_enable;
  } apcr_strobe_s;

endpackage

// [apcr_port_checker.sv]
// Purpose: timing checks on the convert/read port pins
// Assumes: strobes reach logic three edges after the pin moves
// Notes:   p_keep needs the byte select held during a conversion
module apcr_checker
#(
  parameter int CONV_CYC = 24
)
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        upper_byte_enable,
  input wire logic        busy_n,
  input wire logic [11:0] out_lines,
  input wire logic [11:0] out_lines_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // busy low time is far above a plain delay: count it instead
  logic [15:0] low_cnt;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      low_cnt <= 16'h0000;
    else if (!busy_n)
      low_cnt <= low_cnt + 16'h0001;
    else
      low_cnt <= 16'h0000;
  end
  localparam int LOW_CYC = 12 * (CONV_CYC / 12);
  wire ube = upper_byte_enable;
  wire go = !cs_n && !ube;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_go; busy_n && go && $fell(rd_n) |-> ##[2:3] !busy_n; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_hold; busy_n && !go && $fell(rd_n) |=> busy_n [*4]; endproperty
  a_hold: assert property (p_hold) else $error("bad start");
  property p_oe; out_lines_oe == {12{$past(!cs_n && !rd_n, 3)}}; endproperty
  a_oe: assert property (p_oe) else $error("bad enable");
  property p_len; $rose(busy_n) |-> low_cnt == 16'(LOW_CYC + 1); endproperty
  a_len: assert property (p_len) else $error("busy length");
  property p_long; !busy_n |-> low_cnt < 16'(LOW_CYC + 1); endproperty
  a_long: assert property (p_long) else $error("busy too long");
  property p_en; $fell(busy_n) |-> out_lines_oe == 12'hfff; endproperty
  a_en: assert property (p_en) else $error("off at start");
  property p_cause; $fell(busy_n) |-> $past(!rd_n, 2) && $past(go, 2); endproperty
  a_cause: assert property (p_cause) else $error("no cause");
  property p_keep; !busy_n && !$fell(busy_n) |-> $stable(out_lines); endproperty
  a_keep: assert property (p_keep) else $error("latch moved");
  property p_mux; $past(ube, 3) && $past(ube, 4) |->
    out_lines[7:4] == 4'h0 && out_lines[3:0] == out_lines[11:8]; endproperty
  a_mux: assert property (p_mux) else $error("byte mux");
endmodule
bind apcr_port apcr_checker #(.CONV_CYC(CONV_CYC)) u_chk (.ref_clk, .rst_n, .cs_n, .rd_n,
  .upper_byte_enable, .busy_n, .out_lines, .out_lines_oe);

// [apcr_host.sv]
// Purpose: host model issuing read strobes
// Assumes: pins move 1 ns after a clock edge
// Notes:   data taken at the last edge of the strobe
module apcr_host
(
  input  wire logic        ref_clk,
  input  wire logic [11:0] bus,
  output logic             cs_n,
  output logic             rd_n,
  output logic             upper_byte_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cs_n, rd_n, upper_byte_enable} = 3'h6;
  task automatic rd(input logic c, u, output logic [11:0] d);
    @(posedge ref_clk);
    #1;
    cs_n = c;
    upper_byte_enable = u;
    rd_n = 1'h0;
    repeat (6) @(posedge ref_clk);
    d = bus;
    #1;
    rd_n = 1'h1;
    cs_n = 1'h1;
    repeat (12) @(posedge ref_clk);
  endtask
endmodule

// [apcr_port_tb_top.sv]
// Purpose: self-checking bench for the convert/read port
// Assumes: short conversion, comparator level held per conversion
// Notes:   undriven lines read back inverted
module apcr_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst_n, cmp_high, busy_n, cs_n, rd_n, upper_byte_enable;
  logic [11:0] out_lines, out_lines_oe, d;
  wire  [11:0] bus = (out_lines_oe === 12'hfff) ? out_lines : ~out_lines;
  int          error_cnt, checks_done, cyc;
  apcr_port #(.CONV_CYC(24)) uut (.ref_clk, .rst_n, .cs_n, .rd_n, .upper_byte_enable,
    .cmp_high, .busy_n, .out_lines, .out_lines_oe);
  apcr_host host (.ref_clk, .bus, .cs_n, .rd_n, .upper_byte_enable);
  initial
  begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [11:0] g, e);
    checks_done++;
    if (g !== e)
      error_cnt++;
    if (g !== e)
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rd_chk(input logic c, u, input logic [11:0] e, input logic b);
    host.rd(c, u, d);
    if (!c)
      chk(d, e);
    chk({11'h0, busy_n}, {11'h0, b});
  endtask
  task automatic idle();
    repeat (40) if (busy_n !== 1'h1) @(posedge ref_clk);
    chk({11'h0, busy_n}, 12'h001);
    repeat (150) @(posedge ref_clk);
  endtask
  task automatic t_ign();
    rd_chk(1'h1, 1'h0, 12'h000, 1'h1);
    rd_chk(1'h1, 1'h1, 12'h000, 1'h1);
    chk(out_lines_oe, 12'h000);
    $display("t_ign done");
  endtask
  task automatic t_conv();
    #1 cmp_high = 1'h1;
    rd_chk(1'h0, 1'h0, 12'h000, 1'h0);
    rd_chk(1'h0, 1'h0, 12'h000, 1'h1);
    idle();
    rd_chk(1'h0, 1'h1, 12'hf0f, 1'h1);
    #1 cmp_high = 1'h0;
    rd_chk(1'h0, 1'h0, 12'hfff, 1'h0);
    idle();
    rd_chk(1'h0, 1'h1, 12'h000, 1'h1);
    $display("t_conv done");
  endtask
  initial
  begin
    rst_n = 1'h0;
    cmp_high = 1'h0;
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'h1;
    t_ign();
    t_conv();
    stop_test();
  end
endmodule
